/* logic/osc_divider_defaults_startup.sv */
// Oscillator divider with factory defaults, gated stabilization and output enabling
`timescale 1ns/10ps
`default_nettype none
module osc_divider_defaults_startup (
   input wire logic REF_CLK_IN,
   input wire logic RSTN_IN,
   input wire logic OUT_GATE_IN,
   input wire logic SLEEP_PIN_N_IN,
   input wire logic EXT_REFERENCE_IN,
   input wire logic PROG_STRAP_IN,
   input wire logic PROG_WR_RATIO_IN,
   input wire logic PROG_WR_ROUTING_IN,
   input wire logic [8:0] PROG_WDATA_IN,
   output logic DIV_CLK_OUT,
   output logic REF_TAP_OUT,
   output logic STAB_BUSY_OUT,
   output logic PROG_MODE_OUT,
   output logic [8:0] RATIO_WORD_OUT,
   output logic [8:0] ROUTING_CONFIG_OUT
);
   typedef struct packed {
      osc_div_pkg::mode_e mode;
      logic [8:0] ratio;
      logic [8:0] cfg;
      logic [2:0] presc_div;
      logic [9:0] div_n;
      logic [2:0] presc_cnt;
      logic [9:0] div_cnt;
      logic [8:0] stab_cnt;
      logic tap_phase;
      logic div_out;
      logic tap_out;
      logic busy;
      logic prog;
      logic [3:0] meta;
      logic [3:0] sync;
      logic ext_prev;
      logic kept;
   } state_s;

   state_s r;
   state_s n;
   logic use_ext;
   logic sleep_req;
   logic mtick;
   logic presc_tick;
   logic div_hi;
   logic gate;

   // Prescaler ratio selected by the routing configuration
   function automatic logic [2:0] presc_value(input logic [8:0] cfg);
      logic [1:0] code;
      code = cfg[osc_div_pkg::PRESC_MSB:osc_div_pkg::PRESC_LSB];
      if (cfg[osc_div_pkg::PRESC_BYP_N_BIT]) begin
         presc_value = osc_div_pkg::PRESC_ONE;
      end else if (code == osc_div_pkg::PRESC_CODE_1) begin
         presc_value = osc_div_pkg::PRESC_ONE;
      end else if (code == osc_div_pkg::PRESC_CODE_2) begin
         presc_value = osc_div_pkg::PRESC_TWO;
      end else begin
         presc_value = osc_div_pkg::PRESC_MAX;
      end
   endfunction

   // Divisor from ratio word, word zero divides by two
   function automatic logic [9:0] divisor(input logic [8:0] ratio, input logic [8:0] cfg);
      if (cfg[osc_div_pkg::RATIO_BYP_BIT]) begin
         divisor = osc_div_pkg::DIV_ONE;
      end else begin
         divisor = {1'b0, ratio} + osc_div_pkg::DIV_OFFSET;
      end
   endfunction

   // Next state of the whole block
   always_comb begin
      n = r;
      n.meta = {PROG_STRAP_IN, EXT_REFERENCE_IN, SLEEP_PIN_N_IN, OUT_GATE_IN};
      n.sync = r.meta;
      n.ext_prev = r.sync[2];
      gate = r.sync[0];
      sleep_req = r.cfg[osc_div_pkg::SLEEP_EN_BIT] & ~r.cfg[osc_div_pkg::SRC_SW_EN_BIT] & ~r.sync[1];
      use_ext = r.cfg[osc_div_pkg::SRC_SW_EN_BIT] ? ~r.sync[1] : r.cfg[osc_div_pkg::EXT_SEL_BIT];
      mtick = use_ext ? (r.sync[2] & ~r.ext_prev) : 1'b1;
      presc_tick = mtick && (r.presc_cnt == r.presc_div - 3'h1);
      // Prescaler and divider counters
      if (mtick) begin
         n.presc_cnt = presc_tick ? 3'h0 : r.presc_cnt + 3'h1;
      end
      if (presc_tick) begin
         n.tap_phase = ~r.tap_phase;
         n.div_cnt = (r.div_cnt >= r.div_n - 10'h001) ? 10'h000 : r.div_cnt + 10'h001;
      end
      div_hi = (r.div_n == osc_div_pkg::DIV_ONE) ? presc_tick : (r.div_cnt < (r.div_n >> 1));
      // Mode sequencing
      case (r.mode)
         osc_div_pkg::ST_BOOT: begin
            n.stab_cnt = r.stab_cnt + 9'h001;
            if (r.stab_cnt == osc_div_pkg::STRAP_SETTLE) begin
               n.stab_cnt = 9'h000;
               n.mode = r.sync[3] ? osc_div_pkg::ST_PROG : osc_div_pkg::ST_WAIT_GATE;
            end
         end
         osc_div_pkg::ST_PROG: begin
            if (PROG_WR_RATIO_IN) begin
               n.ratio = PROG_WDATA_IN;
               n.kept = 1'b1;
            end
            if (PROG_WR_ROUTING_IN) begin
               n.cfg = PROG_WDATA_IN;
               n.kept = 1'b1;
            end
         end
         osc_div_pkg::ST_WAIT_GATE: begin
            n.presc_div = osc_div_pkg::PRESC_MAX;
            n.div_n = osc_div_pkg::DIV_MAX;
            n.stab_cnt = 9'h000;
            if (gate) begin
               n.mode = osc_div_pkg::ST_STAB;
            end
         end
         osc_div_pkg::ST_STAB: begin
            if (mtick) begin
               n.stab_cnt = r.stab_cnt + 9'h001;
            end
            if (mtick && r.stab_cnt == osc_div_pkg::STAB_LAST) begin
               n.mode = osc_div_pkg::ST_RUN;
               n.presc_div = presc_value(r.cfg);
               n.div_n = divisor(r.ratio, r.cfg);
               n.presc_cnt = 3'h0;
               n.div_cnt = 10'h000;
               n.tap_phase = 1'b0;
            end
         end
         osc_div_pkg::ST_RUN: begin
            n.mode = osc_div_pkg::ST_RUN;
         end
         default: begin
            if (!sleep_req) begin
               n.mode = osc_div_pkg::ST_WAIT_GATE;
            end
         end
      endcase
      // Sleep request from the wait-for-gate, stabilization and run modes
      if (sleep_req && (r.mode == osc_div_pkg::ST_WAIT_GATE || r.mode == osc_div_pkg::ST_STAB ||
                        r.mode == osc_div_pkg::ST_RUN)) begin
         n.mode = osc_div_pkg::ST_SLEEP;
         n.div_cnt = 10'h000;
         n.presc_cnt = 3'h0;
      end
      n.div_out = (r.mode == osc_div_pkg::ST_RUN) && gate && div_hi;
      n.tap_out = (r.mode == osc_div_pkg::ST_RUN) && !r.cfg[osc_div_pkg::TAP_EN_N_BIT] && r.tap_phase;
      n.busy = (n.mode == osc_div_pkg::ST_WAIT_GATE) || (n.mode == osc_div_pkg::ST_STAB);
      n.prog = (n.mode == osc_div_pkg::ST_PROG);
   end

   // State register with defaults at reset
   always_ff @(posedge REF_CLK_IN) begin
      if (!RSTN_IN) begin
         r <= '0;
         r.mode <= osc_div_pkg::ST_BOOT;
         r.presc_div <= osc_div_pkg::PRESC_MAX;
         r.div_n <= osc_div_pkg::DIV_MAX;
         // Programmed words survive power cycles, so normal mode runs with them
         if (r.kept) begin
            r.kept <= 1'b1;
            r.ratio <= r.ratio;
            r.cfg <= r.cfg;
         end else begin
            r.ratio <= osc_div_pkg::RATIO_RESET;
            r.cfg <= osc_div_pkg::CFG_RESET;
         end
      end else begin
         r <= n;
      end
   end

   // Outputs straight from the state register
   assign DIV_CLK_OUT = r.div_out;
   assign REF_TAP_OUT = r.tap_out;
   assign STAB_BUSY_OUT = r.busy;
   assign PROG_MODE_OUT = r.prog;
   assign RATIO_WORD_OUT = r.ratio;
   assign ROUTING_CONFIG_OUT = r.cfg;

   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (!RSTN_IN);

   sequence s_stab_end;
      r.mode == osc_div_pkg::ST_STAB && mtick && r.stab_cnt == osc_div_pkg::STAB_LAST;
   endsequence

   a_ratio_default: assert property (($rose(RSTN_IN) && !r.kept) |-> r.ratio == osc_div_pkg::RATIO_RESET)
      else $error("ratio word not zero after reset");
   a_routing_default: assert property (($rose(RSTN_IN) && !r.kept) |-> r.cfg == osc_div_pkg::CFG_RESET)
      else $error("routing config not default after reset");
   a_sleep_pin_role: assert property ((r.mode == osc_div_pkg::ST_RUN && r.cfg == osc_div_pkg::CFG_RESET
      && !r.sync[1]) |=> r.mode == osc_div_pkg::ST_SLEEP && !use_ext)
      else $error("default pin did not act as sleep");
   a_divider_used: assert property ((s_stab_end ##0 !r.cfg[osc_div_pkg::RATIO_BYP_BIT])
      |=> r.div_n == {1'b0, r.ratio} + osc_div_pkg::DIV_OFFSET)
      else $error("divider not loaded from ratio word");
   a_internal_ref: assert property ((!r.cfg[osc_div_pkg::EXT_SEL_BIT] && !r.cfg[osc_div_pkg::SRC_SW_EN_BIT])
      |-> mtick)
      else $error("internal reference not ticking every cycle");
   a_strap_normal: assert property ((r.mode == osc_div_pkg::ST_BOOT && r.stab_cnt == osc_div_pkg::STRAP_SETTLE
      && !r.sync[3]) |=> r.mode == osc_div_pkg::ST_WAIT_GATE ##1 !PROG_MODE_OUT)
      else $error("normal mode not entered without strap");
   a_gate_delays: assert property ((r.mode == osc_div_pkg::ST_WAIT_GATE && !gate && !sleep_req)
      |=> r.mode == osc_div_pkg::ST_WAIT_GATE && r.stab_cnt == 9'h000)
      else $error("interval started with gate low");
   a_gate_holds_low: assert property ((r.mode == osc_div_pkg::ST_RUN && !gate) |=> !DIV_CLK_OUT)
      else $error("divided output not held low by gate");
   a_tap_never: assert property ((r.mode == osc_div_pkg::ST_WAIT_GATE && !gate) [*2] |=> !REF_TAP_OUT)
      else $error("tap started without gate");
   a_ext_count: assert property ((r.mode == osc_div_pkg::ST_STAB && use_ext && !mtick && !sleep_req)
      |=> $stable(r.stab_cnt) && r.mode == osc_div_pkg::ST_STAB)
      else $error("interval advanced without external edge");
   a_forced_max: assert property ((r.mode == osc_div_pkg::ST_STAB)
      |-> r.presc_div == osc_div_pkg::PRESC_MAX && r.div_n == osc_div_pkg::DIV_MAX)
      else $error("ratios not forced during interval");
   a_load_after: assert property ((s_stab_end ##0 !sleep_req) |=> r.mode == osc_div_pkg::ST_RUN
      && r.presc_div == presc_value(r.cfg) && r.div_n == divisor(r.ratio, r.cfg))
      else $error("programmed ratios not loaded after interval");
   a_outputs_idle: assert property ((r.mode != osc_div_pkg::ST_RUN) |=> !DIV_CLK_OUT && !REF_TAP_OUT)
      else $error("output active before enabling finished");
endmodule
`default_nettype wire

/* logic/osc_div_pkg.sv */
// Constants, field layout and mode enumeration for the oscillator divider start-up block
`default_nettype none
package osc_div_pkg;
   localparam int RATIO_W = 9;
   localparam int CFG_W = 9;
   localparam int DIVN_W = 10;
   localparam logic [8:0] RATIO_RESET = 9'h000;
   localparam logic [8:0] CFG_RESET = 9'h034;
   // Routing configuration field positions
   localparam int EXT_SEL_BIT = 0;
   localparam int RATIO_BYP_BIT = 1;
   localparam int PRESC_BYP_N_BIT = 2;
   localparam int SRC_SW_EN_BIT = 3;
   localparam int SLEEP_EN_BIT = 4;
   localparam int TAP_EN_N_BIT = 5;
   localparam int PRESC_LSB = 6;
   localparam int PRESC_MSB = 7;
   // Prescaler codes
   localparam logic [1:0] PRESC_CODE_1 = 2'h1;
   localparam logic [1:0] PRESC_CODE_2 = 2'h2;
   localparam logic [2:0] PRESC_ONE = 3'h1;
   localparam logic [2:0] PRESC_TWO = 3'h2;
   localparam logic [2:0] PRESC_MAX = 3'h4;
   // Divider limits
   localparam logic [9:0] DIV_ONE = 10'h001;
   localparam logic [9:0] DIV_OFFSET = 10'h002;
   localparam logic [9:0] DIV_MAX = 10'h201;
   // Stabilization interval in master clock ticks and strap settle delay
   localparam logic [8:0] STAB_LAST = 9'h0ff;
   localparam logic [8:0] STRAP_SETTLE = 9'h002;
   typedef enum logic [2:0] {ST_BOOT, ST_PROG, ST_WAIT_GATE, ST_STAB, ST_RUN, ST_SLEEP} mode_e;
endpackage
`default_nettype wire

/* dv/board_pins.sv */
// Board-side model of the gate, sleep, strap and external reference pins
`timescale 1ns/10ps
`default_nettype none
module board_pins (
   input wire logic clk_in,
   input wire logic gate_req_in,
   input wire logic sleep_req_in,
   input wire logic strap_req_in,
   output logic gate_out,
   output logic sleep_n_out,
   output logic ext_ref_out,
   output logic strap_out
);
   logic [2:0] ref_cnt_r = 3'h0;
   logic gate_r = 1'b0;
   logic sleep_n_r = 1'b1;
   logic strap_r = 1'b0;
   // gate may drop at any time, also mid-interval
   always_ff @(posedge clk_in) begin
      gate_r <= gate_req_in;
      sleep_n_r <= !sleep_req_in;
      strap_r <= strap_req_in;
      ref_cnt_r <= ref_cnt_r + 3'h1;
   end
   // slow free-running reference, eight clocks a period
   assign ext_ref_out = ref_cnt_r[2];
   assign gate_out = gate_r;
   assign sleep_n_out = sleep_n_r;
   assign strap_out = strap_r;
endmodule
`default_nettype wire

/* dv/osc_divider_defaults_startup_tb.sv */
// Self-checking bench for the oscillator divider start-up block
`timescale 1ns/10ps
`default_nettype none
module osc_divider_defaults_startup_tb;
   logic clk;
   logic rstn;
   logic gate_req;
   logic sleep_req;
   logic strap_req;
   logic wr_ratio;
   logic wr_routing;
   logic [8:0] wdata;
   wire logic gate;
   wire logic sleep_n;
   wire logic ext_ref;
   wire logic strap;
   logic div_clk;
   logic ref_tap;
   logic busy;
   logic prog_mode;
   logic [8:0] ratio;
   logic [8:0] routing;
   int err_count;
   int check_count;
   int n;
   int h;
   int t;
   logic act;
   board_pins pins (.clk_in(clk), .gate_req_in(gate_req), .sleep_req_in(sleep_req), .strap_req_in(strap_req),
      .gate_out(gate), .sleep_n_out(sleep_n), .ext_ref_out(ext_ref), .strap_out(strap));
   osc_divider_defaults_startup dut (.REF_CLK_IN(clk), .RSTN_IN(rstn), .OUT_GATE_IN(gate),
      .SLEEP_PIN_N_IN(sleep_n), .EXT_REFERENCE_IN(ext_ref), .PROG_STRAP_IN(strap),
      .PROG_WR_RATIO_IN(wr_ratio), .PROG_WR_ROUTING_IN(wr_routing), .PROG_WDATA_IN(wdata),
      .DIV_CLK_OUT(div_clk), .REF_TAP_OUT(ref_tap), .STAB_BUSY_OUT(busy), .PROG_MODE_OUT(prog_mode),
      .RATIO_WORD_OUT(ratio), .ROUTING_CONFIG_OUT(routing));
   task automatic complete_run();
      if (err_count == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [8:0] exp, input logic [8:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic power_up(input logic s);
      @(posedge clk);
      strap_req <= s;
      rstn <= 1'b0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
   endtask
   // Counts busy cycles and notes any output activity meanwhile
   task automatic stab_count();
      n = 0;
      act = 1'b0;
      for (int i = 0; i < 600 && busy !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      while (busy === 1'b1 && n < 3000) begin
         act = act | div_clk | ref_tap;
         n++;
         @(posedge clk);
         #1;
      end
   endtask
   task automatic highs(input int cyc);
      h = 0;
      t = 0;
      repeat (cyc) begin
         @(posedge clk);
         #1;
         h += int'(div_clk !== 1'b0);
         t += int'(ref_tap !== 1'b0);
      end
   endtask
   task automatic defaults_run();
      power_up(1'b0);
      stab_count();
      check("ratio", 9'h000, ratio);
      check("routing", 9'h034, routing);
      check("ratio_byp", 9'h000, 9'(routing[osc_div_pkg::RATIO_BYP_BIT]));
      check("ext_sel", 9'h000, 9'(routing[osc_div_pkg::EXT_SEL_BIT]));
      check("sleep_en", 9'h001, 9'(routing[osc_div_pkg::SLEEP_EN_BIT]));
      check("src_sw_en", 9'h000, 9'(routing[osc_div_pkg::SRC_SW_EN_BIT]));
      check("stab_len", 9'h001, 9'(n >= 256 && n <= 262));
      check("quiet", 9'h000, 9'(act));
      highs(8);
      check("div_highs", 9'h004, 9'(h));
      check("tap", 9'h000, 9'(ref_tap));
   endtask
   task automatic gate_late();
      @(posedge clk);
      gate_req <= 1'b0;
      power_up(1'b0);
      repeat (400) @(posedge clk);
      #1;
      check("busy_wait", 9'h001, 9'(busy));
      check("div_wait", 9'h000, 9'(div_clk));
      check("tap_wait", 9'h000, 9'(ref_tap));
      @(posedge clk);
      gate_req <= 1'b1;
      stab_count();
      check("late_len", 9'h001, 9'(n >= 256 && n <= 262));
   endtask
   task automatic gate_drop_sleep();
      power_up(1'b0);
      repeat (60) @(posedge clk);
      gate_req <= 1'b0;
      stab_count();
      highs(20);
      check("div_held", 9'h000, 9'(h));
      @(posedge clk);
      gate_req <= 1'b1;
      repeat (8) @(posedge clk);
      highs(8);
      check("div_back", 9'h004, 9'(h));
      @(posedge clk);
      sleep_req <= 1'b1;
      repeat (6) @(posedge clk);
      highs(20);
      check("sleep_div", 9'h000, 9'(h));
      check("sleep_busy", 9'h000, 9'(busy));
      @(posedge clk);
      sleep_req <= 1'b0;
      stab_count();
      check("wake_len", 9'h001, 9'(n >= 256 && n <= 262));
   endtask
   task automatic program_then_run();
      power_up(1'b1);
      repeat (8) @(posedge clk);
      wdata <= 9'h1a5;
      wr_ratio <= 1'b1;
      @(posedge clk);
      wdata <= 9'h0c3;
      wr_ratio <= 1'b0;
      wr_routing <= 1'b1;
      @(posedge clk);
      wr_routing <= 1'b0;
      @(posedge clk);
      #1;
      check("prog_mode", 9'h001, 9'(prog_mode));
      check("ratio_wr", 9'h1a5, ratio);
      check("routing_wr", 9'h0c3, routing);
      // Programmed words select the external reference, prescaler 4, divider bypass, tap on
      power_up(1'b0);
      stab_count();
      check("ext_len", 9'h001, 9'(n >= 2040 && n <= 2056));
      repeat (8) @(posedge clk);
      wdata <= 9'h155;
      wr_ratio <= 1'b1;
      @(posedge clk);
      wr_ratio <= 1'b0;
      @(posedge clk);
      #1;
      check("normal_mode", 9'h000, 9'(prog_mode));
      check("ratio_locked", 9'h1a5, ratio);
      check("routing_kept", 9'h0c3, routing);
      repeat (64) @(posedge clk);
      highs(64);
      check("ext_div_highs", 9'h002, 9'(h));
      check("ext_tap_highs", 9'h020, 9'(t));
   endtask
   // Free-running bench clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Watchdog well beyond the expected run length
   initial begin
      #(50 * 8000);
      err_count++;
      complete_run();
   end
   // Main sequence
   initial begin
      rstn = 1'b0;
      gate_req = 1'b1;
      sleep_req = 1'b0;
      strap_req = 1'b0;
      wr_ratio = 1'b0;
      wr_routing = 1'b0;
      wdata = 9'h000;
      err_count = 0;
      check_count = 0;
      defaults_run();
      gate_late();
      gate_drop_sleep();
      program_then_run();
      complete_run();
   end
endmodule
`default_nettype wire
